// *** rtl/dual_queue_request_dispatcher.sv ***
// Command block agent: fetch dispatcher, write and read queues, two execution units.
// Assumes the fetched request stream, transfer engine and status writer sit outside.
//
// Notes on behaviour
// - Take request blocks strictly in list order.
// - Write class to write queue, read to read.
// - Top two function bits select the handling unit.
// - Each unit runs its queue in arrival order.
// - Post status after a command when notify set.
// - Each unit posts status in completion order.
// - Re-read next pointer only of null-terminated block.
// - Offer data-available when outbound data and idle reader.
// - Track sequence number and offset of active request.
// - After restart, complete each unit's last executed request without transfer.
// - Resume partly processed request from saved offset.
// - Channel identifier travels with requests and status.
// - Channel open/close go to separate management port.
// - Channel FFFF never names an ordinary data channel.
`timescale 1ns/1ps
module dual_queue_request_dispatcher (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rstn,
  // Fetched request blocks
  input  wire logic                          i_orb_valid,
  input  wire dispatch_pkg::orb_t            i_orb,
  output logic                               o_orb_ready,
  output logic                               o_poll_null_next,
  // Recovery control
  input  wire logic                          i_abort,
  input  wire logic                          i_restart,
  output logic                               o_halted,
  // Transfer engine, one lane per unit
  output logic [1:0]                         o_xfer_req,
  output dispatch_pkg::xfer_t [1:0]          o_xfer,
  input  wire logic [1:0]                    i_xfer_done,
  input  wire logic [1:0][dispatch_pkg::LEN_W-1:0] i_xfer_offset,
  // Status writer, one lane per unit
  output logic [1:0]                         o_status_valid,
  output dispatch_pkg::status_t [1:0]        o_status,
  input  wire logic [1:0]                    i_status_ack,
  // Channel management unit
  output logic                               o_chm_valid,
  output dispatch_pkg::orb_t                 o_chm_orb,
  input  wire logic                          i_chm_ack,
  // Rejected blocks
  output logic [1:0]                         o_reject,
  // Outbound data indication
  input  wire logic                          i_outbound_pending,
  input  wire logic                          i_unsol_enable,
  output logic                               o_data_avail,
  output logic                               o_data_avail_unsol,
  // Queue depths
  output logic [dispatch_pkg::CNT_W-1:0]     o_write_depth,
  output logic [dispatch_pkg::CNT_W-1:0]     o_read_depth
);

  logic [1:0]                          push;
  logic [1:0]                          pop;
  logic [1:0][dispatch_pkg::CNT_W-1:0] cnt_reg;
  logic [1:0][dispatch_pkg::CNT_W-1:0] cnt_next;
  logic [1:0]                          unit_idle;
  logic                                accept;
  logic [1:0]                          cat;
  logic                                chan_is_mgmt;
  logic                                chm_take;
  logic                                bad_chan;
  logic                                halted_next;
  logic                                chm_valid_next;
  logic                                ready_next;

  // Dispatch decode
  always_comb begin
    accept       = i_orb_valid & o_orb_ready;
    cat          = i_orb.func[dispatch_pkg::CAT_MSB:dispatch_pkg::CAT_LSB];
    chan_is_mgmt = (i_orb.chan == dispatch_pkg::CHAN_MGMT);
    bad_chan     = accept & chan_is_mgmt & (cat == dispatch_pkg::CAT_WRITE | cat == dispatch_pkg::CAT_READ);
    push[dispatch_pkg::UNIT_WR] = accept & (cat == dispatch_pkg::CAT_WRITE) & ~chan_is_mgmt;
    push[dispatch_pkg::UNIT_RD] = accept & (cat == dispatch_pkg::CAT_READ) & ~chan_is_mgmt;
    chm_take     = accept & (cat == dispatch_pkg::CAT_CHM);
  end

  // Queue occupancy and next-cycle readiness
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      if (i_abort) begin
        cnt_next[u] = '0;
      end else begin
        cnt_next[u] = cnt_reg[u] + dispatch_pkg::CNT_W'(push[u]) - dispatch_pkg::CNT_W'(pop[u]);
      end
    end
    halted_next    = i_abort | (o_halted & ~i_restart);
    chm_valid_next = chm_take | (o_chm_valid & ~i_chm_ack);
    ready_next     = ~halted_next & ~chm_valid_next
                   & (cnt_next[dispatch_pkg::UNIT_WR] < dispatch_pkg::DEPTH_RST)
                   & (cnt_next[dispatch_pkg::UNIT_RD] < dispatch_pkg::DEPTH_RST);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Fetch side handshake and halt after abort
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_orb_ready <= 1'b0;
      o_halted    <= 1'b0;
    end else begin
      o_orb_ready <= ready_next;
      o_halted    <= halted_next;
    end
  end

  // Only a null-terminated block has its next pointer polled again
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_poll_null_next <= 1'b0;
    end else if (i_abort) begin
      o_poll_null_next <= 1'b0;
    end else if (accept) begin
      o_poll_null_next <= i_orb.null_next;
    end
  end

  // Channel management hand-off
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_chm_valid <= 1'b0;
      o_chm_orb   <= '0;
    end else begin
      o_chm_valid <= chm_valid_next;
      if (chm_take) begin
        o_chm_orb <= i_orb;
      end
    end
  end

  // Reject pulses for service-dependent codes and misused channel
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reject <= dispatch_pkg::REJ_NONE;
    end else if (accept & (cat == dispatch_pkg::CAT_SVC)) begin
      o_reject <= dispatch_pkg::REJ_SVC;
    end else if (bad_chan) begin
      o_reject <= dispatch_pkg::REJ_CHAN;
    end else begin
      o_reject <= dispatch_pkg::REJ_NONE;
    end
  end

  // Data-available offer while the read side has nothing to do
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_data_avail       <= 1'b0;
      o_data_avail_unsol <= 1'b0;
    end else begin
      o_data_avail       <= i_outbound_pending & ~o_halted & (cnt_reg[dispatch_pkg::UNIT_RD] == '0)
                          & unit_idle[dispatch_pkg::UNIT_RD];
      o_data_avail_unsol <= i_outbound_pending & ~o_halted & i_unsol_enable
                          & (cnt_reg[dispatch_pkg::UNIT_RD] == '0) & unit_idle[dispatch_pkg::UNIT_RD];
    end
  end

  // Fixed queue depths
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_write_depth <= dispatch_pkg::DEPTH_RST;
      o_read_depth  <= dispatch_pkg::DEPTH_RST;
    end else begin
      o_write_depth <= dispatch_pkg::DEPTH_RST;
      o_read_depth  <= dispatch_pkg::DEPTH_RST;
    end
  end

  // Per-unit queue and execution unit
  for (genvar u = 0; u < 2; u++) begin : g_unit
    dispatch_pkg::orb_t              mem [dispatch_pkg::QDEPTH];
    logic [dispatch_pkg::PTR_W-1:0]  wr_ptr_reg;
    logic [dispatch_pkg::PTR_W-1:0]  rd_ptr_reg;
    dispatch_pkg::exec_state_t       state_reg;
    dispatch_pkg::orb_t              head;
    logic                            done_valid_reg;
    logic [dispatch_pkg::SEQ_W-1:0]  done_seq_reg;
    dispatch_pkg::chan_t             done_chan_reg;
    logic                            part_valid_reg;
    logic [dispatch_pkg::SEQ_W-1:0]  part_seq_reg;
    dispatch_pkg::chan_t             part_chan_reg;
    logic [dispatch_pkg::LEN_W-1:0]  part_off_reg;
    logic                            cur_notify_reg;
    logic                            is_done;
    logic                            is_part;

    always_comb begin
      head      = mem[rd_ptr_reg];
      pop[u]    = (state_reg == dispatch_pkg::EX_IDLE) & (cnt_reg[u] != '0) & ~i_abort;
      unit_idle[u] = (state_reg == dispatch_pkg::EX_IDLE);
      is_done   = done_valid_reg & (head.buffer_sequence_number == done_seq_reg)
                & (head.chan == done_chan_reg);
      is_part   = part_valid_reg & (head.buffer_sequence_number == part_seq_reg)
                & (head.chan == part_chan_reg);
    end

    // Queue storage kept in arrival order
    always_ff @(posedge i_clk) begin
      if (push[u]) begin
        mem[wr_ptr_reg] <= i_orb;
      end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
      end else if (i_abort) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
      end else begin
        wr_ptr_reg <= wr_ptr_reg + dispatch_pkg::PTR_W'(push[u]);
        rd_ptr_reg <= rd_ptr_reg + dispatch_pkg::PTR_W'(pop[u]);
      end
    end

    // Execution sequence
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        state_reg         <= dispatch_pkg::EX_IDLE;
        o_xfer_req[u]     <= 1'b0;
        o_xfer[u]         <= '0;
        o_status_valid[u] <= 1'b0;
        o_status[u]       <= '0;
        cur_notify_reg    <= 1'b0;
      end else if (i_abort) begin
        state_reg         <= dispatch_pkg::EX_IDLE;
        o_xfer_req[u]     <= 1'b0;
        o_status_valid[u] <= 1'b0;
      end else begin
        unique case (state_reg)
          dispatch_pkg::EX_IDLE: begin
            if (pop[u]) begin
              o_status[u].func                   <= head.func;
              o_status[u].chan                   <= head.chan;
              o_status[u].buffer_sequence_number <= head.buffer_sequence_number;
              cur_notify_reg                     <= head.notify;
              if (is_done) begin
                o_status[u].skipped <= 1'b1;
                o_status_valid[u]   <= head.notify;
                state_reg           <= head.notify ? dispatch_pkg::EX_POST : dispatch_pkg::EX_IDLE;
              end else begin
                o_status[u].skipped              <= 1'b0;
                o_xfer[u].chan                   <= head.chan;
                o_xfer[u].buffer_sequence_number <= head.buffer_sequence_number;
                o_xfer[u].tag                    <= head.tag;
                o_xfer[u].data_size              <= head.data_size;
                o_xfer[u].start_offset           <= is_part ? part_off_reg : '0;
                o_xfer_req[u]                    <= 1'b1;
                state_reg                        <= dispatch_pkg::EX_XFER;
              end
            end
          end
          dispatch_pkg::EX_XFER: begin
            if (i_xfer_done[u]) begin
              o_xfer_req[u]     <= 1'b0;
              o_status_valid[u] <= cur_notify_reg;
              state_reg         <= cur_notify_reg ? dispatch_pkg::EX_POST : dispatch_pkg::EX_IDLE;
            end
          end
          dispatch_pkg::EX_POST: begin
            if (i_status_ack[u]) begin
              o_status_valid[u] <= 1'b0;
              state_reg         <= dispatch_pkg::EX_IDLE;
            end
          end
        endcase
      end
    end

    // Progress tracking for recovery, kept through an abort
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        done_valid_reg <= 1'b0;
        done_seq_reg   <= '0;
        done_chan_reg  <= '0;
        part_valid_reg <= 1'b0;
        part_seq_reg   <= '0;
        part_chan_reg  <= '0;
        part_off_reg   <= '0;
      end else if (state_reg == dispatch_pkg::EX_XFER) begin
        if (i_xfer_done[u]) begin
          done_valid_reg <= 1'b1;
          done_seq_reg   <= o_xfer[u].buffer_sequence_number;
          done_chan_reg  <= o_xfer[u].chan;
          part_valid_reg <= 1'b0;
        end else begin
          part_valid_reg <= 1'b1;
          part_seq_reg   <= o_xfer[u].buffer_sequence_number;
          part_chan_reg  <= o_xfer[u].chan;
          part_off_reg   <= i_xfer_offset[u];
        end
      end
    end
  end : g_unit

endmodule : dual_queue_request_dispatcher

// *** rtl/dispatch_pkg.sv ***
// Shared types and constants for the dual queue request dispatcher.
// Assumes one system clock; request blocks arrive already fetched from initiator memory.
package dispatch_pkg;

  localparam int          QDEPTH    = 8;
  localparam int          PTR_W     = 3;
  localparam int          CNT_W     = 4;
  localparam int          SEQ_W     = 7;
  localparam int          CHAN_W    = 16;
  localparam int          LEN_W     = 16;
  localparam int          UNIT_WR   = 0;
  localparam int          UNIT_RD   = 1;
  localparam int          CAT_MSB   = 7;
  localparam int          CAT_LSB   = 6;
  localparam logic [1:0]  CAT_WRITE = 2'h0;
  localparam logic [1:0]  CAT_READ  = 2'h1;
  localparam logic [1:0]  CAT_SVC   = 2'h2;
  localparam logic [1:0]  CAT_CHM   = 2'h3;
  localparam logic [15:0] CHAN_MGMT = 16'hffff;
  localparam logic [CNT_W-1:0] DEPTH_RST = CNT_W'(QDEPTH);
  localparam logic [1:0]  REJ_NONE  = 2'h0;
  localparam logic [1:0]  REJ_SVC   = 2'h1;
  localparam logic [1:0]  REJ_CHAN  = 2'h2;

  typedef enum logic [1:0] {
    EX_IDLE,
    EX_XFER,
    EX_POST
  } exec_state_t;

  typedef struct packed {
    logic [7:0]       initiator_process_channel_id;
    logic [7:0]       target_endpoint_channel_id;
  } chan_t;

  typedef struct packed {
    logic [7:0]       func;
    chan_t            chan;
    logic [SEQ_W-1:0] buffer_sequence_number;
    logic             notify;
    logic             null_next;
    logic             tag;
    logic [LEN_W-1:0] data_size;
  } orb_t;

  typedef struct packed {
    chan_t            chan;
    logic [SEQ_W-1:0] buffer_sequence_number;
    logic             tag;
    logic [LEN_W-1:0] start_offset;
    logic [LEN_W-1:0] data_size;
  } xfer_t;

  typedef struct packed {
    logic [7:0]       func;
    chan_t            chan;
    logic [SEQ_W-1:0] buffer_sequence_number;
    logic             skipped;
  } status_t;

endpackage : dispatch_pkg

// *** bench/dispatcher_asserts.sv ***
// Concurrent checks on the dispatcher ports.
// Assumes it is bound onto dual_queue_request_dispatcher.
`timescale 1ns/1ps
module dispatcher_asserts (
  // Clock and reset
  input wire logic                            i_clk,
  input wire logic                            i_rstn,
  // Watched ports
  input wire logic                            i_orb_valid,
  input wire dispatch_pkg::orb_t              i_orb,
  input wire logic                            o_orb_ready,
  input wire logic                            o_poll_null_next,
  input wire logic                            i_abort,
  input wire logic                            o_halted,
  input wire logic [1:0]                      o_xfer_req,
  input wire dispatch_pkg::xfer_t [1:0]       o_xfer,
  input wire logic [1:0]                      i_xfer_done,
  input wire logic [1:0]                      o_status_valid,
  input wire dispatch_pkg::status_t [1:0]     o_status,
  input wire logic [1:0]                      i_status_ack,
  input wire logic                            o_chm_valid,
  input wire dispatch_pkg::orb_t              o_chm_orb,
  input wire logic                            i_chm_ack,
  input wire logic [1:0]                      o_reject,
  input wire logic                            o_data_avail,
  input wire logic                            o_data_avail_unsol,
  input wire logic [dispatch_pkg::CNT_W-1:0]  o_write_depth,
  input wire logic [dispatch_pkg::CNT_W-1:0]  o_read_depth
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic take;
  assign take = i_orb_valid && o_orb_ready && !i_abort;
  depth_fixed_a: assert property (o_write_depth == 4'h8 && o_read_depth == 4'h8)
    else $error("queue depth not eight");
  halt_stall_a: assert property (o_halted && $past(o_halted) |-> !o_orb_ready)
    else $error("block taken while halted");
  svc_reject_a: assert property (take && i_orb.func[7:6] == 2'h2 |=> o_reject == 2'h1)
    else $error("service code not rejected");
  chan_reject_a: assert property (take && !i_orb.func[7] && i_orb.chan == 16'hffff |=> o_reject == 2'h2)
    else $error("data command on management channel not rejected");
  chm_route_a: assert property (take && i_orb.func[7:6] == 2'h3 |=> o_chm_valid && o_chm_orb == $past(i_orb))
    else $error("management block not routed");
  chm_hold_a: assert property (o_chm_valid && !i_chm_ack && !i_abort |=> o_chm_valid)
    else $error("management request dropped");
  xfer_hold_a: assert property (o_xfer_req[0] && !i_xfer_done[0] && !i_abort |=> o_xfer_req[0] && $stable(o_xfer[0]))
    else $error("write transfer not held");
  status_hold_a: assert property (o_status_valid[1] && !i_status_ack[1] && !i_abort
    |=> o_status_valid[1] && $stable(o_status[1]))
    else $error("read status not held");
  null_poll_a: assert property (take && i_orb.null_next |=> o_poll_null_next)
    else $error("null next pointer not flagged");
  avail_gate_a: assert property (o_data_avail_unsol |-> o_data_avail)
    else $error("unsolicited without data available");
  avail_busy_a: assert property (o_xfer_req[1] && $past(o_xfer_req[1]) |-> !o_data_avail)
    else $error("data available while reading");
  reject_take_a: assert property (o_reject != 2'h0 |-> $past(i_orb_valid && o_orb_ready))
    else $error("reject without taken block");
  cover property (take && i_orb.func[7:6] == 2'h3);
  cover property (i_abort && o_xfer_req[0]);
  cover property (o_status_valid[0] && o_status[0].skipped);
endmodule : dispatcher_asserts

bind dual_queue_request_dispatcher dispatcher_asserts i_chk (.i_clk, .i_rstn, .i_orb_valid, .i_orb, .o_orb_ready,
  .o_poll_null_next, .i_abort, .o_halted, .o_xfer_req, .o_xfer, .i_xfer_done, .o_status_valid, .o_status,
  .i_status_ack, .o_chm_valid, .o_chm_orb, .i_chm_ack, .o_reject, .o_data_avail, .o_data_avail_unsol,
  .o_write_depth, .o_read_depth);

// *** bench/host_responder.sv ***
// Far side model: transfer engine, status writer and management acknowledges.
// Assumes requests are held until answered, answers land on the falling edge.
`timescale 1ns/1ps
module host_responder (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Requests and pacing
  input  wire logic [4:0]  i_req,
  input  wire logic        i_slow,
  // Answers
  output logic [4:0]       o_ans,
  output logic [1:0][15:0] o_offset
);
  logic [4:0]      wait_reg;
  logic [4:0][5:0] cnt_reg;
  always_ff @(negedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ans    <= '0;
      wait_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      for (int l = 0; l < 5; l++) begin
        o_ans[l] <= 1'b0;
        if (!i_req[l]) begin
          cnt_reg[l]  <= '0;
          wait_reg[l] <= 1'b0;
        end else if (!wait_reg[l]) begin
          cnt_reg[l] <= cnt_reg[l] + 6'h1;
          if (cnt_reg[l] >= (i_slow ? 6'h1e : 6'h02)) begin
            o_ans[l]    <= 1'b1;
            wait_reg[l] <= 1'b1;
          end
        end
      end
    end
  end
  // Offset past start while busy, inverted when idle
  assign o_offset[0] = i_req[0] ? 16'h0100 : 16'hfeff;
  assign o_offset[1] = i_req[1] ? 16'h0100 : 16'hfeff;
endmodule : host_responder

// *** bench/tb.sv ***
// Self-checking bench for the dual queue request dispatcher.
// Assumes host_responder on the far side and the bound checker.
`timescale 1ns/1ps
module tb;
  logic                        i_clk = 1'b0;
  logic                        i_rstn = 1'b0;
  logic                        orb_valid = 1'b0;
  dispatch_pkg::orb_t          orb = '0;
  logic                        abort = 1'b0;
  logic                        restart = 1'b0;
  logic                        slow = 1'b0;
  logic                        pending = 1'b0;
  logic                        unsol = 1'b0;
  logic [4:0]                  ans;
  logic [1:0][15:0]            offset;
  logic                        ready, poll_null, halted, chm_valid, avail, avail_unsol;
  logic [1:0]                  xfer_req, status_valid, reject;
  logic [1:0]                  prev_req = 2'h0;
  dispatch_pkg::xfer_t [1:0]   xfer;
  dispatch_pkg::status_t [1:0] status;
  dispatch_pkg::orb_t          chm_orb;
  logic [3:0]                  wdepth, rdepth;
  logic [31:0]                 stat_q[2][$];
  logic [7:0]                  rej_q[$], chm_q[$];
  logic [15:0]                 start_off[2];
  logic [7:0]                  fn[8] = '{8'h00, 8'h3f, 8'h40, 8'h7f, 8'h80, 8'hbf, 8'hc1, 8'hc2};
  int                          xfer_n[2] = '{0, 0};
  int                          fail_count = 0;
  int                          checks_done = 0;
  int                          cyc = 0;
  int                          n;

  always #4 i_clk = ~i_clk;

  dual_queue_request_dispatcher i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_orb_valid(orb_valid), .i_orb(orb),
    .o_orb_ready(ready), .o_poll_null_next(poll_null), .i_abort(abort), .i_restart(restart), .o_halted(halted),
    .o_xfer_req(xfer_req), .o_xfer(xfer), .i_xfer_done(ans[1:0]), .i_xfer_offset(offset),
    .o_status_valid(status_valid), .o_status(status), .i_status_ack(ans[3:2]), .o_chm_valid(chm_valid),
    .o_chm_orb(chm_orb), .i_chm_ack(ans[4]), .o_reject(reject), .i_outbound_pending(pending),
    .i_unsol_enable(unsol), .o_data_avail(avail), .o_data_avail_unsol(avail_unsol),
    .o_write_depth(wdepth), .o_read_depth(rdepth));

  host_responder i_host (.i_clk(i_clk), .i_rstn(i_rstn), .i_req({chm_valid, status_valid, xfer_req}),
    .i_slow(slow), .o_ans(ans), .o_offset(offset));

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
    for (int l = 0; l < 2; l++) begin
      if (status_valid[l] && ans[l+2])
        stat_q[l].push_back({status[l].func, status[l].chan, status[l].buffer_sequence_number, status[l].skipped});
      if (xfer_req[l] && !prev_req[l]) begin
        start_off[l] = xfer[l].start_offset;
        xfer_n[l]++;
      end
    end
    prev_req <= xfer_req;
    if (reject != 2'h0) rej_q.push_back({6'h0, reject});
    if (chm_valid && ans[4]) chm_q.push_back(chm_orb.func);
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic send(input logic [7:0] f, input logic [15:0] c, input logic [6:0] s, input logic nt, input logic z);
    int k = 0;
    @(negedge i_clk);
    orb_valid = 1'b1;
    orb = '{func: f, chan: dispatch_pkg::chan_t'(c), buffer_sequence_number: s, notify: nt, null_next: z,
            tag: 1'b0, data_size: 16'h0040};
    while (ready !== 1'b1 && k < 500) begin
      @(negedge i_clk);
      k++;
    end
    chk("ready", 32'h1, ready);
    @(posedge i_clk);
  endtask : send

  task automatic idle();
    @(negedge i_clk);
    orb_valid = 1'b0;
    orb = ~orb;
  endtask : idle

  task automatic settle();
    int q = 0;
    int k = 0;
    while (q < 8 && k < 1000) begin
      @(negedge i_clk);
      k++;
      q = (xfer_req === 2'h0 && status_valid === 2'h0 && chm_valid === 1'b0) ? q + 1 : 0;
    end
  endtask : settle

  task automatic stat(input int l, input logic [7:0] f, input logic [15:0] c, input logic [6:0] s, input logic sk);
    if (stat_q[l].size() == 0) chk("status present", 32'h1, 32'h0);
    else chk("status", {f, c, s, sk}, stat_q[l].pop_front());
  endtask : stat

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  initial begin
    repeat (16) @(negedge i_clk);
    chk("depths", 32'h88, {wdepth, rdepth});
    chk("ready in reset", 32'h0, ready);
    i_rstn = 1'b1;
    for (int i = 0; i < 8; i++) send(fn[i], 16'h0102, 7'(i), 1'b1, 1'b0);
    send(8'h00, 16'hffff, 7'h0, 1'b1, 1'b0);
    send(8'h40, 16'hffff, 7'h0, 1'b1, 1'b0);
    idle();
    settle();
    for (int i = 0; i < 4; i++) stat(i / 2, fn[i], 16'h0102, 7'(i), 1'b0);
    for (int i = 0; i < 4; i++) chk("reject", (i < 2) ? 32'h1 : 32'h2, rej_q[i]);
    chk("reject count", 32'h4, rej_q.size());
    chk("chm open", 32'hc1, chm_q[0]);
    chk("chm close", 32'hc2, chm_q[1]);
    for (int i = 0; i < 5; i++) send(8'h00, 16'h0203, 7'(16 + i), i != 2, 1'b0);
    send(8'h40, 16'h0203, 7'h20, 1'b1, 1'b0);
    send(8'h40, 16'h0203, 7'h21, 1'b1, 1'b1);
    idle();
    chk("poll null", 32'h1, poll_null);
    settle();
    for (int i = 0; i < 5; i++) if (i != 2) stat(0, 8'h00, 16'h0203, 7'(16 + i), 1'b0);
    stat(1, 8'h40, 16'h0203, 7'h20, 1'b0);
    stat(1, 8'h40, 16'h0203, 7'h21, 1'b0);
    chk("extra status", 32'h0, stat_q[0].size());
    slow = 1'b1;
    send(8'h00, 16'h0304, 7'h30, 1'b1, 1'b0);
    idle();
    repeat (12) @(negedge i_clk);
    abort = 1'b1;
    @(negedge i_clk);
    abort = 1'b0;
    @(negedge i_clk);
    chk("halt ready poll", 32'h4, {halted, ready, poll_null});
    restart = 1'b1;
    @(negedge i_clk);
    restart = 1'b0;
    slow = 1'b0;
    send(8'h00, 16'h0304, 7'h30, 1'b1, 1'b0);
    idle();
    settle();
    chk("resume offset", 32'h0100, start_off[0]);
    stat(0, 8'h00, 16'h0304, 7'h30, 1'b0);
    n = xfer_n[0];
    send(8'h00, 16'h0304, 7'h30, 1'b1, 1'b0);
    idle();
    settle();
    chk("repeat transfer", n, xfer_n[0]);
    stat(0, 8'h00, 16'h0304, 7'h30, 1'b1);
    pending = 1'b1;
    repeat (4) @(negedge i_clk);
    chk("avail", 32'h2, {avail, avail_unsol});
    unsol = 1'b1;
    repeat (2) @(negedge i_clk);
    chk("avail unsol", 32'h3, {avail, avail_unsol});
    slow = 1'b1;
    send(8'h40, 16'h0304, 7'h31, 1'b1, 1'b0);
    idle();
    repeat (4) @(negedge i_clk);
    chk("avail busy", 32'h0, {avail, avail_unsol});
    slow = 1'b0;
    settle();
    stat(1, 8'h40, 16'h0304, 7'h31, 1'b0);
    test_done();
  end
endmodule : tb
